// *** pkg/sac_pkg.sv ***
// Purpose: shared constants for the converter control block
// Assumes: 20 MHz system clock, classic Wishbone register access
// Notes:   register offsets are byte addresses of aligned 32-bit words
package sac_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_CHANNEL  = 8'h00;
    localparam logic [7:0] OFS_REFERENCE_PINS   = 8'h04;
    localparam logic [7:0] OFS_TIMING_FORMAT    = 8'h08;
    localparam logic [7:0] OFS_RESULT_HIGH      = 8'h0C;
    localparam logic [7:0] OFS_RESULT_LOW       = 8'h10;
    localparam logic [7:0] OFS_STATUS           = 8'h14;

    // control channel fields
    localparam int BIT_CONVERTER_ENABLE  = 0;
    localparam int BIT_TRIGGER           = 1;
    localparam int POS_CHANNEL_SELECT    = 2;
    // reference and pin fields
    localparam int POS_PIN_ANALOG_CONFIG = 0;
    localparam int BIT_VREF_POS          = 4;
    localparam int BIT_VREF_NEG          = 5;
    // timing and format fields
    localparam int POS_CLOCK_SELECT      = 0;
    localparam int POS_ACQ_SELECT        = 3;
    localparam int BIT_RESULT_JUSTIFY    = 7;
    // status fields
    localparam int BIT_DONE_FLAG         = 0;
    localparam int BIT_BUSY              = 1;

    // values after reset
    localparam logic [7:0] RST_CONTROL_CHANNEL = 8'h00;
    localparam logic [1:0] RST_VREF            = 2'h0;
    localparam logic [3:0] RST_PCFG_ANALOG     = 4'h0;
    localparam logic [3:0] RST_PCFG_MIXED      = 4'h7;
    localparam logic [7:0] RST_TIMING_FORMAT   = 8'h00;
    localparam logic [1:0] STRAP_WAIT_CYC      = 2'h3;

    // channel and pin counts
    localparam int           NUM_INPUTS     = 13;
    localparam logic [3:0]   LAST_CHANNEL   = 4'hC;
    localparam logic [3:0]   PCFG_ALL_ANALOG = 4'h2;
    localparam int           RESULT_BITS    = 10;
    localparam logic [3:0]   CONV_LAST_STEP = 4'hA;

    // timing: clock period, internal rc bit period, instruction cycle
    localparam int CLK_PERIOD_NS  = 50;
    localparam int RC_TAD_NS      = 4000;
    localparam int RC_TAD_CYC     = RC_TAD_NS / CLK_PERIOD_NS;
    localparam int TCY_NS         = 200;
    localparam int TCY_CYC        = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SAC_IDLE  = 2'b00,
        SAC_DELAY = 2'b01,
        SAC_ACQ   = 2'b11,
        SAC_CONV  = 2'b10
    } sac_state_type;

endpackage

// *** hw/sac_adc_control.sv ***
// Purpose: control logic of a 10-bit successive-approximation converter
// Assumes: classic Wishbone slave, one 20 MHz clock, synchronous low reset
// Notes:   the rc bit clock is a divider of the system clock; it alone runs in sleep
`timescale 1ns/1ns
module sac_adc_control #(
    parameter int RC_DIV  = sac_pkg::RC_TAD_CYC,
    parameter int TCY_DIV = sac_pkg::TCY_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        comparator_i,
    input  wire logic        sleep_i,
    input  wire logic        portb_analog_default_i,
    output logic             converter_on_o,
    output logic             sample_o,
    output logic      [9:0]  sar_code_o,
    output logic      [3:0]  channel_select_o,
    output logic             channel_valid_o,
    output logic             vref_neg_ext_o,
    output logic             vref_pos_ext_o,
    output logic      [12:0] pin_analog_o,
    output logic             conversion_done_flag_o
);

    if (RC_DIV < 2 || RC_DIV > 255) begin : g_chk_rc
        $error("RC_DIV must lie in 2..255");
    end
    if (TCY_DIV < 1 || TCY_DIV > 15) begin : g_chk_tcy
        $error("TCY_DIV must lie in 1..15");
    end

    localparam logic [7:0] RC_LAST  = 8'(RC_DIV - 1);
    localparam logic [3:0] TCY_LAST = 4'(TCY_DIV - 1);

    // system clock divide for a clock code; rc codes return zero
    function automatic logic [7:0] sys_div(input logic [2:0] code);
        case (code)
            3'h0:    sys_div = 8'h02;
            3'h1:    sys_div = 8'h08;
            3'h2:    sys_div = 8'h20;
            3'h4:    sys_div = 8'h04;
            3'h5:    sys_div = 8'h10;
            3'h6:    sys_div = 8'h40;
            default: sys_div = 8'h00;
        endcase
    endfunction

    // acquisition length in bit periods
    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        case (code)
            3'h0:    acq_periods = 5'h00;
            3'h1:    acq_periods = 5'h02;
            3'h2:    acq_periods = 5'h04;
            3'h3:    acq_periods = 5'h06;
            3'h4:    acq_periods = 5'h08;
            3'h5:    acq_periods = 5'h0C;
            3'h6:    acq_periods = 5'h10;
            default: acq_periods = 5'h14;
        endcase
    endfunction

    // analog mask: pins below the digital boundary stay analog
    function automatic logic [12:0] analog_mask(input logic [3:0] code);
        logic [3:0] n_dig;
        n_dig = 4'h0;
        analog_mask = '0;
        if (code > sac_pkg::PCFG_ALL_ANALOG) begin
            n_dig = code - sac_pkg::PCFG_ALL_ANALOG;
        end
        for (int i = 0; i < sac_pkg::NUM_INPUTS; i++) begin
            analog_mask[i] = (i < (sac_pkg::NUM_INPUTS - int'(n_dig)));
        end
    endfunction

    // register state
    logic [7:0]  ctl_reg, ctl_next;
    logic [1:0]  vref_reg, vref_next;
    logic [3:0]  pcfg_reg, pcfg_next;
    logic [7:0]  tim_reg, tim_next;
    logic [9:0]  result_reg;
    logic        done_reg, done_next;
    logic        ack_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  strap_wait_reg;
    logic        strap_meta_reg, strap_sync_reg;
    logic        comp_sync_reg;

    // engine state
    sac_pkg::sac_state_type state_reg, state_next;
    logic [7:0]  div_cnt_reg;
    logic [7:0]  rc_cnt_reg;
    logic [3:0]  tcy_cnt_reg;
    logic [4:0]  acq_cnt_reg;
    logic [3:0]  step_reg;
    logic [9:0]  sar_reg;

    // field views
    wire         enable_w     = ctl_reg[sac_pkg::BIT_CONVERTER_ENABLE];
    wire         trigger_w    = ctl_reg[sac_pkg::BIT_TRIGGER];
    wire  [3:0]  chan_w       = ctl_reg[sac_pkg::POS_CHANNEL_SELECT +: 4];
    wire  [2:0]  clk_sel_w    = tim_reg[sac_pkg::POS_CLOCK_SELECT +: 3];
    wire  [2:0]  acq_sel_w    = tim_reg[sac_pkg::POS_ACQ_SELECT +: 3];
    wire         justify_w    = tim_reg[sac_pkg::BIT_RESULT_JUSTIFY];
    wire  [7:0]  div_w        = sys_div(clk_sel_w);
    wire         rc_sel_w     = (div_w == 8'h00);
    wire  [4:0]  acq_len_w    = acq_periods(acq_sel_w);

    // bus decode
    wire         req_w        = wb_cyc_i && wb_stb_i && !ack_reg;
    wire         wr_w         = req_w && wb_we_i && wb_sel_i[0];
    wire  [7:0]  wbyte_w      = wb_dat_i[7:0];
    wire         hit_ctl_w    = (wb_adr_i == sac_pkg::OFS_CONTROL_CHANNEL);
    wire         hit_ref_w    = (wb_adr_i == sac_pkg::OFS_REFERENCE_PINS);
    wire         hit_tim_w    = (wb_adr_i == sac_pkg::OFS_TIMING_FORMAT);
    wire         hit_rhi_w    = (wb_adr_i == sac_pkg::OFS_RESULT_HIGH);
    wire         hit_rlo_w    = (wb_adr_i == sac_pkg::OFS_RESULT_LOW);
    wire         hit_sta_w    = (wb_adr_i == sac_pkg::OFS_STATUS);
    wire         wr_ctl_w     = wr_w && hit_ctl_w;

    wire  [15:0] result_pair_w = justify_w ? {6'h00, result_reg} : {result_reg, 6'h00};

    // bit period tick: rc divider runs free, system divider only awake
    wire         rc_tick_w    = (rc_cnt_reg == RC_LAST);
    wire         sys_tick_w   = !sleep_i && (div_cnt_reg == div_w - 8'h01);
    wire         tad_tick_w   = rc_sel_w ? rc_tick_w : sys_tick_w;
    wire         conv_end_w   = (state_reg == sac_pkg::SAC_CONV) && tad_tick_w
                                && (step_reg == sac_pkg::CONV_LAST_STEP);
    wire         start_w      = wr_ctl_w && wbyte_w[sac_pkg::BIT_TRIGGER]
                                && wbyte_w[sac_pkg::BIT_CONVERTER_ENABLE]
                                && (state_reg == sac_pkg::SAC_IDLE);
    // aborting: module switched off or trigger written low
    wire         abort_w      = wr_ctl_w && (!wbyte_w[sac_pkg::BIT_CONVERTER_ENABLE]
                                || !wbyte_w[sac_pkg::BIT_TRIGGER]);

    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl_w) begin
            ctl_next = {2'b00, wbyte_w[5:0]};
            if (!wbyte_w[sac_pkg::BIT_CONVERTER_ENABLE] || state_reg != sac_pkg::SAC_IDLE) begin
                ctl_next[sac_pkg::BIT_TRIGGER] = trigger_w && wbyte_w[sac_pkg::BIT_TRIGGER]
                                                 && wbyte_w[sac_pkg::BIT_CONVERTER_ENABLE];
            end
        end
        if (conv_end_w) begin
            ctl_next[sac_pkg::BIT_TRIGGER] = 1'b0;
        end
    end

    // other registers next value
    always_comb begin
        vref_next = vref_reg;
        pcfg_next = pcfg_reg;
        tim_next  = tim_reg;
        done_next = done_reg;
        if (wr_w && hit_ref_w) begin
            vref_next = wbyte_w[5:4];
            pcfg_next = wbyte_w[3:0];
        end
        if (strap_wait_reg == 2'h1) begin
            pcfg_next = strap_sync_reg ? sac_pkg::RST_PCFG_ANALOG : sac_pkg::RST_PCFG_MIXED;
        end
        if (wr_w && hit_tim_w) begin
            tim_next = {wbyte_w[7], 1'b0, wbyte_w[5:0]};
        end
        // done flag: write one clears, completion sets and wins
        if (wr_w && hit_sta_w && wbyte_w[sac_pkg::BIT_DONE_FLAG]) begin
            done_next = 1'b0;
        end
        if (conv_end_w) begin
            done_next = 1'b1;
        end
    end

    // read data mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_ctl_w) begin
            rdata_next[7:0] = ctl_reg;
        end else if (hit_ref_w) begin
            rdata_next[7:0] = {2'b00, vref_reg, pcfg_reg};
        end else if (hit_tim_w) begin
            rdata_next[7:0] = tim_reg;
        end else if (hit_rhi_w) begin
            rdata_next[7:0] = result_pair_w[15:8];
        end else if (hit_rlo_w) begin
            rdata_next[7:0] = result_pair_w[7:0];
        end else if (hit_sta_w) begin
            rdata_next[sac_pkg::BIT_DONE_FLAG] = done_reg;
            rdata_next[sac_pkg::BIT_BUSY]      = (state_reg != sac_pkg::SAC_IDLE);
        end
    end

    // conversion sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sac_pkg::SAC_IDLE: begin
                if (start_w) begin
                    // rc source waits an instruction cycle
                    if (rc_sel_w) begin
                        state_next = sac_pkg::SAC_DELAY;
                    end else if (acq_len_w != 5'h00) begin
                        state_next = sac_pkg::SAC_ACQ;
                    end else begin
                        state_next = sac_pkg::SAC_CONV;
                    end
                end
            end
            sac_pkg::SAC_DELAY: begin
                if (tcy_cnt_reg == TCY_LAST) begin
                    state_next = (acq_len_w != 5'h00) ? sac_pkg::SAC_ACQ : sac_pkg::SAC_CONV;
                end
            end
            sac_pkg::SAC_ACQ: begin
                if (tad_tick_w && acq_cnt_reg == acq_len_w - 5'h01) begin
                    state_next = sac_pkg::SAC_CONV;
                end
            end
            sac_pkg::SAC_CONV: begin
                if (conv_end_w) begin
                    state_next = sac_pkg::SAC_IDLE;
                end
            end
            default: state_next = sac_pkg::SAC_IDLE;
        endcase
        if (abort_w) begin
            state_next = sac_pkg::SAC_IDLE;
        end
    end

    // synchronisers for pins; the comparator answers a trial code launched on this
    // clock, so one register: a second would outlast a two-cycle bit period
    always_ff @(posedge sys_clk_i) begin
        comp_sync_reg  <= comparator_i;
        strap_meta_reg <= portb_analog_default_i;
        strap_sync_reg <= strap_meta_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ctl_reg        <= sac_pkg::RST_CONTROL_CHANNEL;
            vref_reg       <= sac_pkg::RST_VREF;
            pcfg_reg       <= sac_pkg::RST_PCFG_ANALOG;
            tim_reg        <= sac_pkg::RST_TIMING_FORMAT;
            done_reg       <= 1'b0;
            strap_wait_reg <= sac_pkg::STRAP_WAIT_CYC;
            ack_reg        <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
        end else begin
            ctl_reg        <= ctl_next;
            vref_reg       <= vref_next;
            pcfg_reg       <= pcfg_next;
            tim_reg        <= tim_next;
            done_reg       <= done_next;
            ack_reg        <= req_w;
            rdata_reg      <= rdata_next;
            if (strap_wait_reg != 2'h0) begin
                strap_wait_reg <= strap_wait_reg - 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_reg <= sac_pkg::SAC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit period dividers; system divider restarts with each conversion
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || rc_tick_w) begin
            rc_cnt_reg <= 8'h00;
        end else begin
            rc_cnt_reg <= rc_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || state_reg == sac_pkg::SAC_IDLE || sys_tick_w) begin
            div_cnt_reg <= 8'h00;
        end else if (!sleep_i) begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // instruction cycle delay and acquisition counters
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || state_reg != sac_pkg::SAC_DELAY) begin
            tcy_cnt_reg <= 4'h0;
        end else begin
            tcy_cnt_reg <= tcy_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || state_reg != sac_pkg::SAC_ACQ) begin
            acq_cnt_reg <= 5'h00;
        end else if (tad_tick_w) begin
            acq_cnt_reg <= acq_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || state_reg != sac_pkg::SAC_CONV) begin
            step_reg <= 4'h0;
            sar_reg  <= 10'h200;
        end else if (tad_tick_w && step_reg != sac_pkg::CONV_LAST_STEP) begin
            step_reg <= step_reg + 4'h1;
            // comparator high keeps the trial bit, next lower bit tried
            sar_reg[4'd9 - step_reg] <= comp_sync_reg;
            if (step_reg != 4'h9) begin
                sar_reg[4'd8 - step_reg] <= 1'b1;
            end
        end
    end

    // result has no reset; loaded at completion
    always_ff @(posedge sys_clk_i) begin
        if (conv_end_w) begin
            result_reg <= sar_reg;
        end
    end

    // outputs
    assign wb_ack_o               = ack_reg;
    assign wb_dat_o               = rdata_reg;
    assign converter_on_o         = enable_w;
    assign sample_o               = enable_w && (state_reg != sac_pkg::SAC_CONV);
    assign sar_code_o             = sar_reg;
    assign channel_select_o       = chan_w;
    assign channel_valid_o        = (chan_w <= sac_pkg::LAST_CHANNEL);
    assign vref_neg_ext_o         = vref_reg[1];
    assign vref_pos_ext_o         = vref_reg[0];
    assign pin_analog_o           = analog_mask(pcfg_reg);
    assign conversion_done_flag_o = done_reg;

endmodule

// *** tb/sac_analog_model.sv ***
// Purpose: analog side of the converter: per-channel input levels and comparator
// Assumes: the bench sets the level of a channel before converting it
// Notes:   unimplemented channels float, so their comparator output toggles
`timescale 1ns/1ns
module sac_analog_model (
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] channel_i,
    input  wire logic [9:0] code_i,
    output logic            comparator_o
);
    logic [9:0] level [0:12] = '{default: 10'h000};
    logic       float_reg    = 1'b0;
    // floating input; a level that changes every cycle, never a held value
    always_ff @(posedge sys_clk_i) begin
        float_reg <= ~float_reg;
    end
    assign comparator_o = (channel_i <= 4'hC) ? (level[channel_i] >= code_i) : float_reg;
endmodule

// *** tb/sac_adc_control_props.sv ***
// Purpose: port assertions for the converter control block
// Assumes: one clock, synchronous active-low reset
// Notes:   write decode mirrors the bus; sel is ignored, which only weakens the checks
`timescale 1ns/1ns
module sac_adc_control_props (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        converter_on_o,
    input wire logic        sample_o,
    input wire logic [3:0]  channel_select_o,
    input wire logic        channel_valid_o,
    input wire logic        vref_neg_ext_o,
    input wire logic [12:0] pin_analog_o,
    input wire logic        conversion_done_flag_o
);
    wire logic take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wr     = take & wb_we_i;
    wire logic wr_ctl = wr & (wb_adr_i == sac_pkg::OFS_CONTROL_CHANNEL);
    wire logic wr_ref = wr & (wb_adr_i == sac_pkg::OFS_REFERENCE_PINS);
    wire logic clr    = wr & (wb_adr_i == sac_pkg::OFS_STATUS) & wb_dat_i[0];
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chan_valid_a: assert property (
        channel_valid_o == (channel_select_o <= sac_pkg::LAST_CHANNEL))
        else $error("channel valid wrong");
    chan_hold_a: assert property (!wr_ctl |=> $stable(channel_select_o))
        else $error("channel changed without write");
    enable_cause_a: assert property ($rose(converter_on_o) |-> $past(wr_ctl & wb_dat_i[0]))
        else $error("enable rose without write");
    off_quiet_a: assert property (!converter_on_o |-> !sample_o)
        else $error("sampling while disabled");
    vref_hold_a: assert property (!wr_ref |=> $stable(vref_neg_ext_o))
        else $error("reference changed without write");
    pin_mask_a: assert property (((pin_analog_o + 13'h1) & pin_analog_o) == 13'h0)
        else $error("analog pins not contiguous from input 0");
    done_hold_a: assert property (conversion_done_flag_o && !clr |=> conversion_done_flag_o)
        else $error("done flag lost");
    done_resume_a: assert property ($rose(conversion_done_flag_o) |-> sample_o)
        else $error("sampling not resumed at done");
    cover property ($rose(conversion_done_flag_o));
    cover property ($fell(sample_o));
    cover property (pin_analog_o == 13'h0);
endmodule
bind sac_adc_control sac_adc_control_props u_props (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .converter_on_o(converter_on_o), .sample_o(sample_o), .channel_select_o(channel_select_o),
    .channel_valid_o(channel_valid_o), .vref_neg_ext_o(vref_neg_ext_o),
    .pin_analog_o(pin_analog_o), .conversion_done_flag_o(conversion_done_flag_o)
);

// *** tb/sac_adc_control_test.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: 20 MHz clock; rc divisor shortened, instruction-cycle divisor kept at its default of 4
// Notes:   conversion length is timed on the done flag port, not by polling
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sac_adc_control_test;
    localparam int RC_DIV  = 4;
    localparam int TCY_DIV = 4;
    int tad_tab [8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
    int acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int          err_total  = 0;
    int          num_checks = 0;
    logic        sys_clk_i = 1'b0, resetn_i = 1'b0, sleep_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        portb_analog_default_i = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, comparator_i, converter_on_o, sample_o, channel_valid_o;
    logic        vref_neg_ext_o, vref_pos_ext_o, conversion_done_flag_o;
    logic [9:0]  sar_code_o;
    logic [3:0]  channel_select_o;
    logic [12:0] pin_analog_o;
    logic [7:0]  q;
    always #25 sys_clk_i = ~sys_clk_i;
    sac_adc_control #(.RC_DIV(RC_DIV), .TCY_DIV(TCY_DIV)) dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator_i(comparator_i),
        .sleep_i(sleep_i), .portb_analog_default_i(portb_analog_default_i),
        .converter_on_o(converter_on_o), .sample_o(sample_o), .sar_code_o(sar_code_o),
        .channel_select_o(channel_select_o), .channel_valid_o(channel_valid_o),
        .vref_neg_ext_o(vref_neg_ext_o), .vref_pos_ext_o(vref_pos_ext_o),
        .pin_analog_o(pin_analog_o), .conversion_done_flag_o(conversion_done_flag_o));
    sac_analog_model model (.sys_clk_i(sys_clk_i), .channel_i(channel_select_o),
        .code_i(sar_code_o), .comparator_o(comparator_i));
    // the first edge lets a released request stay low for a cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            n++;
        end
        `CHK(n < 20, 1'b1)
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        `CHK(q, e)
    endtask
    task automatic rst(input logic s);
        portb_analog_default_i <= s;
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
    endtask
    task automatic conv(input logic [2:0] clk, input logic [2:0] acq, input logic [3:0] ch);
        int n, lo, hi;
        logic [9:0] v;
        logic       rj;
        n  = 0;
        rj = clk[0] ^ acq[0];
        v  = {ch, acq, clk};
        model.level[ch] = v;
        bus(8'h08, 1'b1, {rj, 1'b0, acq, clk});
        bus(8'h14, 1'b1, 8'h01);
        `CHK(conversion_done_flag_o, 1'b0)
        bus(8'h00, 1'b1, {2'b00, ch, 2'b11});
        while (conversion_done_flag_o !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_i);
            n++;
        end
        // system sources tick in step with the start; the free rc divider may
        // land anywhere in its first period after the instruction-cycle delay
        hi = (acq_tab[acq] + 11) * tad_tab[clk];
        lo = hi;
        if (clk[1:0] == 2'b11) begin
            hi = hi + TCY_DIV;
            lo = hi - RC_DIV + 1;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
        `CHK(sample_o, 1'b1)
        rd_chk(8'h00, {2'b00, ch, 2'b01});
        rd_chk(8'h0C, rj ? {6'h00, v[9:8]} : v[9:2]);
        rd_chk(8'h10, rj ? v[7:0] : {v[1:0], 6'h00});
        repeat (3 * tad_tab[clk]) @(posedge sys_clk_i);
    endtask
    task automatic t_regs;
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h04, 8'h00);
        `CHK(pin_analog_o, 13'h1FFF)
        bus(8'h1C, 1'b1, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        bus(8'h08, 1'b1, 8'hFF);
        rd_chk(8'h08, 8'hBF);
        bus(8'h00, 1'b1, 8'hFC);
        rd_chk(8'h00, 8'h3C);
        `CHK(converter_on_o, 1'b0)
        $display("test regs done");
    endtask
    task automatic t_pins_chan;
        for (int c = 0; c < 16; c++) begin
            bus(8'h04, 1'b1, {2'b00, c[0], c[1], c[3:0]});
            `CHK(pin_analog_o, (13'h1 << (c < 3 ? 13 : 15 - c)) - 13'h1)
            `CHK({vref_neg_ext_o, vref_pos_ext_o}, {c[0], c[1]})
            bus(8'h00, 1'b1, {2'b00, c[3:0], 2'b00});
            `CHK({channel_select_o, channel_valid_o}, {c[3:0], c < 13})
        end
        $display("test pins and channels done");
    endtask
    task automatic t_conv;
        for (int a = 0; a < 8; a++) conv(3'h0, a[2:0], a[3:0]);
        // rc sources run with the device asleep, system-clock ones awake
        for (int k = 0; k < 8; k++) begin
            sleep_i <= (k[1:0] == 2'b11);
            conv(k[2:0], 3'h0, 4'hC - k[3:0]);
        end
        sleep_i <= 1'b0;
        $display("test conversions done");
    endtask
    task automatic t_abort_sleep;
        bus(8'h08, 1'b1, 8'h06);
        bus(8'h14, 1'b1, 8'h01);
        bus(8'h00, 1'b1, 8'h03);
        rd_chk(8'h00, 8'h03);
        rd_chk(8'h14, 8'h02);
        `CHK(sample_o, 1'b0)
        bus(8'h00, 1'b1, 8'h01);
        rd_chk(8'h00, 8'h01);
        bus(8'h00, 1'b1, 8'h02);
        rd_chk(8'h00, 8'h00);
        repeat (800) @(posedge sys_clk_i);
        `CHK(conversion_done_flag_o, 1'b0)
        sleep_i <= 1'b1;
        bus(8'h08, 1'b1, 8'h00);
        bus(8'h00, 1'b1, 8'h03);
        repeat (100) @(posedge sys_clk_i);
        `CHK(conversion_done_flag_o, 1'b0)
        sleep_i <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        `CHK(conversion_done_flag_o, 1'b1)
        $display("test abort and sleep done");
    endtask
    task automatic t_reset;
        bus(8'h08, 1'b1, 8'h06);
        bus(8'h00, 1'b1, 8'h03);
        rst(1'b0);
        rd_chk(8'h00, 8'h00);
        `CHK(conversion_done_flag_o, 1'b0)
        repeat (4) @(posedge sys_clk_i);
        rd_chk(8'h04, 8'h07);
        `CHK(pin_analog_o, 13'h00FF)
        $display("test reset done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        rst(1'b1);
        t_regs;
        t_pins_chan;
        t_conv;
        t_abort_sleep;
        t_reset;
        wrap_up;
    end
    initial begin
        #2_000_000;
        err_total++;
        wrap_up;
    end
endmodule
